// ### core/umb_pkg.sv
// Package: register map, field layout, carriers and states of the modem status and rate block.
package umb_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] MSR_ADDR = 32'h4000_5018;
	localparam logic [31:0] SCR_ADDR = 32'h4000_501C;
	localparam logic [31:0] FRC_ADDR = 32'h4000_5024;
	localparam logic [31:0] DIV_ADDR = 32'h4000_5028;
	localparam logic [7:0] SCR_RESET = 8'h00;
	localparam logic [15:0] FRC_RESET = 16'h0000;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [3:0] FLAG_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int FRC_EN_BIT = 15;
	localparam int FRC_M_MSB = 12;
	localparam int FRC_M_LSB = 11;
	localparam int FRC_N_MSB = 10;
	localparam logic [15:0] FRC_WMASK = 16'h9FFF;
	localparam logic [7:0] UPPER_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Rate generator sizing
	// ----------------------------------------------------------------
	localparam int PRE_W = 4;
	localparam int FRAC_W = 10;
	localparam logic [PRE_W-1:0] PRE_ONE = 4'h1;
	localparam logic [15:0] DIV_ONE = 16'h0001;

	// ----------------------------------------------------------------
	// Carriers and states
	// ----------------------------------------------------------------
	// Modem lines in the order of status bits 7 down to 4.
	typedef struct packed {
		logic carrier;
		logic ring;
		logic set_ready;
		logic clear_send;
	} umb_modem_t;

	// Pins idle high, so status reads zero out of reset.
	localparam umb_modem_t PIN_IDLE = 4'hF;

	typedef struct packed {
		logic en;
		logic [1:0] m;
		logic [10:0] n;
		logic [15:0] div;
	} umb_rate_cfg_t;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_ACK = 2'b01
	} umb_apb_state_t;

endpackage

// ### core/umb_rate_gen.sv
// Bit rate generator: fractional prescaler followed by the integer divider.
`timescale 1ns/100ps

module umb_rate_gen
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire umb_pkg::umb_rate_cfg_t i_cfg,
	output logic o_tick16
);
	import umb_pkg::*;

	logic [PRE_W-1:0] pre_cnt;
	logic [FRAC_W-1:0] frac_acc;
	logic [15:0] div_cnt;
	logic [PRE_W-1:0] next_pre_cnt;

	// ----------------------------------------------------------------
	// Prescaler and divider decode
	// ----------------------------------------------------------------
	// Each prescaler period lasts 2M cycles plus N/1024 on average; the carry gives 0 to 2 extra.
	wire [FRAC_W+1:0] frac_sum = {2'b00, frac_acc} + {1'b0, i_cfg.n};
	wire [PRE_W-1:0] frac_period = {1'b0, i_cfg.m, 1'b0} + {2'b00, frac_sum[FRAC_W+1:FRAC_W]};
	wire pre_end = pre_cnt <= PRE_ONE;
	wire pre_tick = ~i_cfg.en | pre_end;
	wire div_hit = div_cnt >= i_cfg.div - DIV_ONE;
	// A zero period from a forbidden M of zero is stretched to one cycle so the count never wraps.
	assign next_pre_cnt = ~i_cfg.en ? PRE_ONE : ~pre_end ? pre_cnt - PRE_ONE :
		(frac_period == '0) ? PRE_ONE : frac_period;

	// Prescaler, fraction accumulator and integer divider.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pre_cnt <= PRE_ONE;
			frac_acc <= '0;
			div_cnt <= '0;
			o_tick16 <= 1'b0;
		end
		else
		begin
			pre_cnt <= next_pre_cnt;
			frac_acc <= ~i_cfg.en ? '0 : pre_end ? frac_sum[FRAC_W-1:0] : frac_acc;
			div_cnt <= ~pre_tick ? div_cnt : div_hit ? '0 : div_cnt + DIV_ONE;
			o_tick16 <= pre_tick & div_hit;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [19:0] gap;
	logic seen;
	logic cfg_mod;
	umb_rate_cfg_t prev_cfg;
	// Both factors are widened first so a large divider cannot overflow the product.
	wire [19:0] lo_span = 20'({i_cfg.m, 1'b0}) * 20'(i_cfg.div);
	wire [19:0] hi_span = 20'({1'b0, i_cfg.m, 1'b0} + 4'h2) * 20'(i_cfg.div);

	// Cycles since the last tick, and whether the setup moved in between.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			gap <= '0;
			seen <= 1'b0;
			cfg_mod <= 1'b0;
			prev_cfg <= '0;
		end
		else
		begin
			gap <= o_tick16 ? 20'h00001 : gap + 20'h00001;
			seen <= seen | o_tick16;
			cfg_mod <= (i_cfg != prev_cfg) | (cfg_mod & ~o_tick16);
			prev_cfg <= i_cfg;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	a_int_period: assert property (
		o_tick16 && seen && !cfg_mod && i_cfg == prev_cfg && !i_cfg.en
		|-> gap == {4'h0, i_cfg.div})
		else $error("integer tick period differs from divider");
	a_frac_period: assert property (
		o_tick16 && seen && !cfg_mod && i_cfg == prev_cfg && i_cfg.en && i_cfg.m != 2'b00
		|-> gap >= lo_span && gap <= hi_span)
		else $error("fractional tick period out of range");
	c_frac_tick: cover property (o_tick16 && seen && i_cfg.en && i_cfg.n != '0);

endmodule

// ### core/umb_modem_rate.sv
// Top: modem status, scratch and bit rate registers behind an APB slave.
`timescale 1ns/100ps

module umb_modem_rate
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire umb_pkg::umb_modem_t i_modem_n,
	output logic o_tick16
);
	import umb_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	umb_modem_t sync_a;
	umb_modem_t sync_b;
	umb_modem_t status;
	umb_modem_t next_status;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [7:0] scratch;
	logic [15:0] frac_ctrl;
	logic [15:0] int_div;
	umb_apb_state_t state;
	umb_apb_state_t next_state;
	umb_rate_cfg_t rate_cfg;

	// ----------------------------------------------------------------
	// Modem line synchroniser
	// ----------------------------------------------------------------
	// Pins are asynchronous; only the second stage feeds any logic.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sync_a <= PIN_IDLE;
			sync_b <= PIN_IDLE;
		end
		else
		begin
			sync_a <= i_modem_n;
			sync_b <= sync_a;
		end
	end

	// ----------------------------------------------------------------
	// Status levels and change detection
	// ----------------------------------------------------------------
	// Status is active high: a low pin reads as one.
	assign next_status = ~sync_b;

	// Changes are found between the registered status and its next value.
	wire carrier_chg = next_status.carrier ^ status.carrier;
	wire ring_trail = next_status.ring & ~status.ring;
	wire set_ready_chg = next_status.set_ready ^ status.set_ready;
	wire clear_send_chg = next_status.clear_send ^ status.clear_send;
	wire [3:0] flag_set = {carrier_chg, ring_trail, set_ready_chg, clear_send_chg};

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire access = i_psel & i_penable;
	wire hit_msr = i_paddr == MSR_ADDR;
	wire hit_scr = i_paddr == SCR_ADDR;
	wire hit_frc = i_paddr == FRC_ADDR;
	wire hit_div = i_paddr == DIV_ADDR;
	wire hit_any = hit_msr | hit_scr | hit_frc | hit_div;
	wire capture = access & (state == APB_IDLE);
	wire done = access & o_pready;
	wire wr_done = done & i_pwrite & ~o_pslverr;
	wire rd_msr_done = done & ~i_pwrite & hit_msr;

	// Only flags that the finishing read actually returned are cleared.
	// A change caught after the data was captured survives for the next read.
	wire [3:0] flag_clr = rd_msr_done ? o_prdata[3:0] : FLAG_RESET;
	// Hardware set wins over the read clear.
	assign next_flags = flag_set | (flags & ~flag_clr);

	// Read data selection; unmapped addresses read zero.
	wire [15:0] msr_word = {UPPER_ZERO, status, flags};
	wire [15:0] scr_word = {UPPER_ZERO, scratch};
	wire [15:0] rd_word = hit_msr ? msr_word :
		hit_scr ? scr_word :
		hit_frc ? frac_ctrl :
		hit_div ? int_div : 16'h0000;

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// One wait state: the data is captured in the first access cycle and
	// pready rises in the second, so every output comes from a flop.
	always_comb
	begin
		case (state)
			APB_IDLE: next_state = access ? APB_ACK : APB_IDLE;
			APB_ACK: next_state = APB_IDLE;
			default: next_state = APB_IDLE;
		endcase
	end

	// Handshake state and registered answer.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state <= APB_IDLE;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end
		else
		begin
			state <= next_state;
			o_pready <= next_state == APB_ACK;
			o_pslverr <= capture ? ~hit_any : o_pslverr & ~done;
			o_prdata <= capture ? {16'h0000, i_pwrite ? 16'h0000 : rd_word} : o_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Modem status register
	// ----------------------------------------------------------------
	// Level bits follow the pins; change flags stay set until read.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			status <= ~PIN_IDLE;
			flags <= FLAG_RESET;
		end
		else
		begin
			status <= next_status;
			flags <= next_flags;
		end
	end

	// ----------------------------------------------------------------
	// Scratch and rate control registers
	// ----------------------------------------------------------------
	// Writes take effect on the completing edge only.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			scratch <= SCR_RESET;
			frac_ctrl <= FRC_RESET;
			int_div <= DIV_RESET;
		end
		else
		begin
			if (wr_done & hit_scr)
			begin
				scratch <= i_pwdata[7:0];
			end
			if (wr_done & hit_frc)
			begin
				frac_ctrl <= i_pwdata[15:0] & FRC_WMASK;
			end
			if (wr_done & hit_div)
			begin
				int_div <= i_pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bit rate generator
	// ----------------------------------------------------------------
	// The scratch byte deliberately stays out of this path.
	assign rate_cfg = '{
		en: frac_ctrl[FRC_EN_BIT],
		m: frac_ctrl[FRC_M_MSB:FRC_M_LSB],
		n: frac_ctrl[FRC_N_MSB:0],
		div: int_div
	};

	// A zero M or divider is tolerated without lockup but gives no defined rate.
	umb_rate_gen u_rate_gen
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_cfg(rate_cfg),
		.o_tick16(o_tick16)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [1:0] age;
	wire settled = age == 2'h3;

	// Edges since reset release, so the pin history is past the reset.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			age <= 2'h0;
		end
		else
		begin
			age <= settled ? age : age + 2'h1;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	a_carrier_level: assert property (
		settled |-> status.carrier == !$past(i_modem_n.carrier, 3))
		else $error("carrier status is not the inverted pin");
	a_ring_level: assert property (
		settled |-> status.ring == !$past(i_modem_n.ring, 3))
		else $error("ring status is not the inverted pin");
	a_ready_level: assert property (
		settled |-> status.set_ready == !$past(i_modem_n.set_ready, 3))
		else $error("set ready status is not the inverted pin");
	a_clear_level: assert property (
		settled |-> o_prdata[31:16] == 16'h0000 && status.clear_send == !$past(i_modem_n.clear_send, 3))
		else $error("clear to send status is not the inverted pin");
	a_sync_stages: assert property (
		settled && !$stable(i_modem_n) |-> ##3 !$stable(status))
		else $error("pin change did not reach status after three edges");
	a_carrier_delta: assert property (
		!$stable(status.carrier) |-> flags[3])
		else $error("carrier change flag missed");
	a_carrier_clear: assert property (
		rd_msr_done && o_prdata[3] && !carrier_chg |=> !flags[3])
		else $error("carrier change flag not cleared by read");
	a_ring_trail: assert property (
		$rose(status.ring) |-> flags[2])
		else $error("ring trailing edge flag missed");
	a_ring_fall: assert property (
		$fell(status.ring) && !$past(flags[2]) |-> !flags[2])
		else $error("ring flag set on a falling ring bit");
	a_ready_delta: assert property (
		!$stable(status.set_ready) |-> flags[1])
		else $error("set ready change flag missed");
	a_flag_hold: assert property (
		flags[1] && !rd_msr_done |=> flags[1])
		else $error("set ready change flag dropped without a read");
	a_clear_delta: assert property (
		!$stable(status.clear_send) |-> flags[0])
		else $error("clear to send change flag missed");
	a_scratch_store: assert property (
		wr_done && hit_scr |=> scratch == $past(i_pwdata[7:0]) && $stable(o_tick16))
		else $error("scratch write not stored");
	a_scratch_upper: assert property (
		o_pready && hit_scr && !i_pwrite |-> o_prdata[31:8] == 24'h000000 && o_prdata[7:0] == scratch)
		else $error("scratch read returns wrong data");
	a_frac_fields: assert property (
		wr_done && hit_frc |=> rate_cfg.n == $past(i_pwdata[10:0]) && frac_ctrl[14:13] == 2'b00)
		else $error("fractional field not stored as written");
	a_apb_wait: assert property (
		access && !o_pready |=> o_pready ##1 !o_pready)
		else $error("access phase did not end after one wait state");

	c_msr_read_flags: cover property (rd_msr_done && o_prdata[3:0] != 4'h0);
	c_ring_trail: cover property ($rose(flags[2]));
	c_scratch_rw: cover property (wr_done && hit_scr ##[1:20] done && hit_scr && !i_pwrite);
	c_bad_addr: cover property (done && o_pslverr);

endmodule

// ### test/umb_modem_model.sv
// Modem partner model: drives the four active-low handshake pins toward a target.
`timescale 1ns/100ps

module umb_modem_model
(
	input wire logic i_clk,
	input wire umb_pkg::umb_modem_t i_target,
	input wire logic [3:0] i_delay,
	output umb_pkg::umb_modem_t o_modem_n
);
	import umb_pkg::*;

	logic [3:0] wait_cnt = 4'h0;

	// A real modem answers at its own pace, so each change waits i_delay cycles first.
	always @(posedge i_clk)
	begin
		if (i_target === o_modem_n)
			wait_cnt <= 4'h0;
		else if (wait_cnt >= i_delay)
			o_modem_n <= i_target;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end

	// Pins rest high, as an idle modem leaves them.
	initial o_modem_n = PIN_IDLE;
endmodule

// ### test/test_uart_modem_status_baud_gen.sv
// Testbench: APB register checks, modem line status and bit rate tick periods.
`timescale 1ns/100ps

module test_uart_modem_status_baud_gen;
	import umb_pkg::*;

	// ----------------------------------------------------------------
	// Signals and bookkeeping
	// ----------------------------------------------------------------
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic o_tick16;
	umb_modem_t modem_n;
	umb_modem_t target = PIN_IDLE;
	logic [3:0] delay = 4'h0;
	logic [31:0] exp_data_q[$];
	logic exp_err_q[$];
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [15:0] t_frc [5] = '{16'h0000, 16'h0000, 16'h8800, 16'h8C00, 16'h9000};
	logic [15:0] t_div [5] = '{16'h0001, 16'h0003, 16'h0002, 16'h0001, 16'h0003};
	int t_per [5] = '{1, 3, 4, 3, 12};

	always #5 i_clk = ~i_clk;

	umb_modem_rate DUT
	(
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.i_modem_n(modem_n),
		.o_tick16(o_tick16)
	);

	umb_modem_model modem
	(
		.i_clk(i_clk),
		.i_target(target),
		.i_delay(delay),
		.o_modem_n(modem_n)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic fail_timeout;
		n_mismatch++;
		$display("timeout at %0t", $time);
		summarize();
	endtask

	// Holds the request until pready is seen; the caller releases with idle, so
	// two calls in a row give back-to-back transfers.
	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		input logic [31:0] exp, input logic err);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		exp_data_q.push_back(exp);
		exp_err_q.push_back(err);
		@(posedge i_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge i_clk);
			if (o_pready === 1'b1)
				break;
		end
		if (k == 20)
			fail_timeout();
	endtask

	task automatic idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk);
	endtask

	// Counts cycles over four tick periods once the new settings have settled.
	task automatic measure(input int per);
		int k;
		int n;
		int c;
		n = 0;
		c = 0;
		for (k = 0; k < 400 && n < 6; k++)
		begin
			@(posedge i_clk);
			if (n >= 2)
				c++;
			if (o_tick16 === 1'b1)
				n++;
		end
		if (n < 6)
			fail_timeout();
		check(32'(c), 32'(4 * per));
	endtask

	// Each completed transfer is compared with the oldest expectation.
	always @(posedge i_clk)
	begin
		if (o_pready === 1'b1)
		begin
			if (exp_data_q.size() == 0)
			begin
				n_mismatch++;
				$display("ERROR t=%0t seen=%h exp=%h", $time, o_pready, 1'b0);
			end
			else
			begin
				check(o_prdata, exp_data_q.pop_front());
				check({31'h0, o_pslverr}, {31'h0, exp_err_q.pop_front()});
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] v;
		logic [3:0] fl;
		void'($urandom(7614));
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		apb(0, MSR_ADDR, 0, 32'h0, 0);
		apb(0, SCR_ADDR, 0, 32'h0, 0);
		apb(0, FRC_ADDR, 0, 32'h0, 0);
		apb(0, DIV_ADDR, 0, 32'h1, 0);
		apb(0, 32'h4000_5020, 0, 32'h0, 1);
		apb(1, 32'h4000_5030, 32'h0000_0005, 32'h0, 1);
		apb(0, DIV_ADDR, 0, 32'h1, 0);
		idle();
		$display("test reset and decode done");
		repeat (4)
		begin
			v = $urandom();
			apb(1, SCR_ADDR, v, 32'h0, 0);
			apb(0, SCR_ADDR, 0, {24'h0, v[7:0]}, 0);
		end
		idle();
		$display("test scratch done");
		apb(1, FRC_ADDR, 32'h0000_FFFF, 32'h0, 0);
		apb(0, FRC_ADDR, 0, {16'h0, FRC_WMASK}, 0);
		v = {19'h0, 2'($urandom_range(3, 1)), 11'($urandom_range(2047, 0))};
		apb(1, FRC_ADDR, v, 32'h0, 0);
		apb(0, FRC_ADDR, 0, v, 0);
		apb(1, MSR_ADDR, 32'h0000_00FF, 32'h0, 0);
		apb(0, MSR_ADDR, 0, 32'h0, 0);
		idle();
		$display("test field masks done");
		// Each pin falls and then rises; only the ring line ignores its rise.
		for (int i = 0; i < 4; i++)
		begin
			for (int up = 0; up < 2; up++)
			begin
				delay <= 4'($urandom_range(5, 0));
				target[i] <= up[0];
				@(posedge i_clk);
				repeat (delay + 6) @(posedge i_clk);
				fl = (up == 1 && i == 2) ? 4'h0 : 4'h1 << i;
				apb(0, MSR_ADDR, 0, {24'h0, ~target, fl}, 0);
				apb(0, MSR_ADDR, 0, {24'h0, ~target, 4'h0}, 0);
				idle();
			end
		end
		$display("test modem lines done");
		for (int t = 0; t < 5; t++)
		begin
			apb(1, DIV_ADDR, {16'h0, t_div[t]}, 32'h0, 0);
			apb(1, FRC_ADDR, {16'h0, t_frc[t]}, 32'h0, 0);
			idle();
			measure(t_per[t]);
		end
		$display("test bit rate done");
		summarize();
	end
endmodule
